// file: common/codec_regs_pkg.sv
/*
 * Constants for the codec indexed register block: direct port offsets,
 * indexed register numbers, field positions and reset values.
 * Assumes a byte-wide host port with one-cycle read and write strobes.
 */
package codec_regs_pkg;

    // Direct ports at the codec base address.
    localparam logic [1:0] port_index   = 2'h0;
    localparam logic [1:0] port_data    = 2'h1;
    localparam logic [1:0] port_status  = 2'h2;
    localparam logic [1:0] port_pio     = 2'h3;

    // Indexed registers.
    localparam logic [4:0] idx_ext_access  = 5'h17;
    localparam logic [4:0] idx_compat_id   = 5'h19;
    localparam logic [4:0] idx_mono_ctl    = 5'h1a;
    localparam logic [4:0] idx_rsvd_a      = 5'h1b;
    localparam logic [4:0] idx_cap_format  = 5'h1c;
    localparam logic [4:0] idx_rsvd_b      = 5'h1d;
    localparam logic [4:0] idx_cap_upper   = 5'h1e;
    localparam logic [4:0] idx_cap_lower   = 5'h1f;

    // Index port fields.
    localparam int index_lo_bit      = 0;
    localparam int global_change_bit = 6;

    // Extended access control fields.
    localparam int ext_freeze_bit   = 0;
    localparam int ext_high_bit     = 2;
    localparam int ext_select_bit   = 3;
    localparam int ext_low_lo_bit   = 4;

    // Mono control fields.
    localparam int mono_atten_lo_bit  = 0;
    localparam int mono_in_mute_bit   = 5;
    localparam int mono_bypass_bit    = 6;
    localparam int mono_out_mute_bit  = 7;

    // Capture format fields.
    localparam int cap_stereo_bit    = 4;
    localparam int cap_fmt_lo_bit    = 5;

    // Extended registers that this block keeps itself.
    localparam logic [4:0] ext_input_mix   = 5'h04;
    localparam logic [4:0] ext_right_mix   = 5'h05;
    localparam logic [4:0] ext_id          = 5'h19;
    localparam logic [4:0] ext_rsvd_first  = 5'h12;
    localparam logic [4:0] ext_rsvd_last   = 5'h18;
    localparam int right_mute_bit          = 7;

    // Reset values.
    localparam logic [7:0] mono_ctl_reset   = 8'ha0;
    localparam logic [7:0] cap_format_reset = 8'h00;
    localparam logic [7:0] cap_count_reset  = 8'h00;
    localparam logic [7:0] ext_reset        = 8'h00;
    localparam logic [7:0] x4_reset         = 8'h84;

    // Operating modes.
    localparam logic [1:0] mode_two   = 2'h1;
    localparam logic [1:0] mode_three = 2'h2;

    // Identification values; these values are arbitrary.
    localparam logic [4:0] chip_id_value = 5'h15;
    localparam logic [2:0] version_value = 3'h5;
    localparam logic [7:0] ext_id_value  = 8'h5a;

    // Fixed mono bypass attenuation in dB.
    localparam logic [3:0] bypass_atten_db = 4'h9;
    localparam logic [3:0] atten_step_db   = 4'h3;

endpackage : codec_regs_pkg

// file: rtl/codec_indexed_regs.sv
/*
 * Indexed register bank of the codec host interface, including the
 * extended register indirection through the extended access register.
 * Assumes host strobes already synchronous to clk, one cycle each, and
 * that mode, capture change enable and other direct ports live elsewhere.
 */
// How it works
// - Identification low five bits hold chip code.
// - Top three identification bits hold fixed version.
// - Bypass routes mono in to out, 9 dB.
// - Output mute: left only mode 3, both mode 2.
// - Input mute: left only mode 3, both mode 2.
// - Four-bit input attenuation, 3 dB per step.
// - Stereo select alternates left and right samples.
// - Capture format independent, shared sample frequency.
// - Capture format changes only with change enable.
// - Capture base bytes read back as written.
// - Decode two direct ports, index and data.
// - Extended registers reachable in mode 3 only.
// - Data-select write turns access into data port.
// - Index port write clears data-select.
// - Extended access bit layout fixed.
// - Freeze holds capture ADPCM state.
// - High index bit reaches registers 16, 17, 25.
`timescale 1ns/1ps
module codec_indexed_regs #(
    parameter int num_ext = 18                  // Storable extended regs
) (
    input  wire logic        clk,               // System clock
    input  wire logic        resetn,            // Synchronous reset, low
    input  wire logic [1:0]  host_addr,         // Direct port select
    input  wire logic        host_wr,           // Write strobe
    input  wire logic        host_rd,           // Read strobe
    input  wire logic [7:0]  host_wdata,        // Write data
    input  wire logic [1:0]  codec_mode,        // Current mode
    input  wire logic        capture_change_en, // Capture change enable
    output logic      [7:0]  host_rdata_q,      // Read data
    output logic      [3:0]  ext_index_q,       // Selected extended index
    output logic             mono_bypass_q,     // Mono in routed to out
    output logic      [3:0]  mono_path_atten_q, // Mono attenuation, steps
    output logic             mono_in_mute_l_q,  // Mono in to left mute
    output logic             mono_in_mute_r_q,  // Mono in to right mute
    output logic             mono_out_mute_l_q, // Left line to mono mute
    output logic             mono_out_mute_r_q, // Right line to mono mute
    output logic             capture_stereo_q,  // Alternate L and R
    output logic      [2:0]  capture_format_q,  // Capture format code
    output logic      [15:0] capture_base_q,    // Capture base count
    output logic             adpcm_freeze_q     // Hold ADPCM state
);

    initial begin
        if (num_ext < 18 || num_ext > 32) begin
            $error("num_ext must be 18 to 32");
        end
    end

    logic [7:0] index_q;
    logic [7:0] ext_ctl_q;
    logic [7:0] mono_ctl_q;
    logic [7:0] cap_fmt_q;
    logic [7:0] cap_upper_q;
    logic [7:0] cap_lower_q;
    logic [7:0] ext_mem_q [num_ext];

    logic       mode3;
    logic       wr_index;
    logic       wr_data;
    logic [4:0] cur_index;
    logic [4:0] ext_addr;
    logic       ext_data_mode;
    logic       fmt_change_ok;

    function automatic logic ext_reserved(input logic [4:0] a);
        ext_reserved = (a >= codec_regs_pkg::ext_rsvd_first) &&
                       (a <= codec_regs_pkg::ext_rsvd_last);
    endfunction : ext_reserved

    function automatic logic ext_stored(input logic [4:0] a);
        ext_stored = (32'(a) < num_ext) && !ext_reserved(a);
    endfunction : ext_stored

    assign mode3     = (codec_mode == codec_regs_pkg::mode_three);
    assign wr_index  = host_wr && (host_addr == codec_regs_pkg::port_index);
    assign wr_data   = host_wr && (host_addr == codec_regs_pkg::port_data);
    assign cur_index = index_q[4:0];
    // The high index bit is honoured only in mode 3.
    assign ext_addr  = {ext_ctl_q[codec_regs_pkg::ext_high_bit] & mode3,
                        ext_ctl_q[7:4]};
    // Extended data access exists only in mode 3.
    assign ext_data_mode = mode3 &&
        (cur_index == codec_regs_pkg::idx_ext_access) &&
        ext_ctl_q[codec_regs_pkg::ext_select_bit];
    assign fmt_change_ok = index_q[codec_regs_pkg::global_change_bit] ||
                           capture_change_en;

    // Index port.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            index_q <= 8'h00;
        end else if (wr_index) begin
            index_q <= host_wdata;
        end
    end

    // Extended access control register.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ext_ctl_q <= 8'h00;
        end else if (wr_index) begin
            // Any index write returns to address mode.
            ext_ctl_q[codec_regs_pkg::ext_select_bit] <= 1'b0;
        end else if (wr_data && !ext_data_mode &&
                     cur_index == codec_regs_pkg::idx_ext_access) begin
            // Reserved bit 1 is not stored and reads as zero.
            ext_ctl_q <= host_wdata & 8'hfd;
        end
    end

    // Extended register storage; reserved and identity slots ignore.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < num_ext; i++) begin
                ext_mem_q[i] <= (5'(i) == codec_regs_pkg::ext_input_mix) ?
                    codec_regs_pkg::x4_reset : codec_regs_pkg::ext_reset;
            end
        end else if (wr_data && ext_data_mode && ext_stored(ext_addr)) begin
            ext_mem_q[ext_addr] <= host_wdata;
        end
    end

    // Mono control; bit 4 is reserved and kept zero.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mono_ctl_q <= codec_regs_pkg::mono_ctl_reset;
        end else if (wr_data && cur_index == codec_regs_pkg::idx_mono_ctl) begin
            mono_ctl_q <= host_wdata & 8'hef;
        end
    end

    // Capture format locked unless a change enable is set.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cap_fmt_q <= codec_regs_pkg::cap_format_reset;
        end else if (wr_data && fmt_change_ok &&
                     cur_index == codec_regs_pkg::idx_cap_format) begin
            cap_fmt_q <= host_wdata & 8'hf0;
        end
    end

    // Capture base count bytes.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cap_upper_q <= codec_regs_pkg::cap_count_reset;
            cap_lower_q <= codec_regs_pkg::cap_count_reset;
        end else if (wr_data) begin
            if (cur_index == codec_regs_pkg::idx_cap_upper) begin
                cap_upper_q <= host_wdata;
            end
            if (cur_index == codec_regs_pkg::idx_cap_lower) begin
                cap_lower_q <= host_wdata;
            end
        end
    end

    // Read path; the identity value never changes.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            host_rdata_q <= 8'h00;
        end else if (host_rd) begin
            case (host_addr)
                codec_regs_pkg::port_index: begin
                    host_rdata_q <= index_q;
                end
                codec_regs_pkg::port_data: begin
                    if (ext_data_mode) begin
                        if (ext_addr == codec_regs_pkg::ext_id) begin
                            host_rdata_q <= codec_regs_pkg::ext_id_value;
                        end else if (ext_stored(ext_addr)) begin
                            host_rdata_q <= ext_mem_q[ext_addr];
                        end else begin
                            host_rdata_q <= 8'h00;
                        end
                    end else begin
                        case (cur_index)
                            codec_regs_pkg::idx_ext_access: begin
                                host_rdata_q <= ext_ctl_q;
                            end
                            codec_regs_pkg::idx_compat_id: begin
                                host_rdata_q <= {
                                    codec_regs_pkg::version_value,
                                    codec_regs_pkg::chip_id_value};
                            end
                            codec_regs_pkg::idx_mono_ctl: begin
                                host_rdata_q <= mono_ctl_q;
                            end
                            codec_regs_pkg::idx_cap_format: begin
                                host_rdata_q <= cap_fmt_q;
                            end
                            codec_regs_pkg::idx_cap_upper: begin
                                host_rdata_q <= cap_upper_q;
                            end
                            codec_regs_pkg::idx_cap_lower: begin
                                host_rdata_q <= cap_lower_q;
                            end
                            default: begin
                                host_rdata_q <= 8'h00;
                            end
                        endcase
                    end
                end
                default: begin
                    // Status and PIO ports belong to other blocks.
                    host_rdata_q <= 8'h00;
                end
            endcase
        end
    end

    // Mixer controls decoded from the registers, registered for timing.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mono_bypass_q     <= 1'b0;
            mono_path_atten_q <= 4'h0;
            mono_in_mute_l_q  <= 1'b0;
            mono_in_mute_r_q  <= 1'b0;
            mono_out_mute_l_q <= 1'b0;
            mono_out_mute_r_q <= 1'b0;
        end else begin
            mono_bypass_q <= mono_ctl_q[codec_regs_pkg::mono_bypass_bit];
            // Bypass forces the fixed 9 dB path, in 3 dB steps.
            if (mono_ctl_q[codec_regs_pkg::mono_bypass_bit]) begin
                mono_path_atten_q <= codec_regs_pkg::bypass_atten_db /
                                     codec_regs_pkg::atten_step_db;
            end else begin
                mono_path_atten_q <= mono_ctl_q[3:0];
            end
            mono_in_mute_l_q <= mono_ctl_q[codec_regs_pkg::mono_in_mute_bit];
            mono_out_mute_l_q <= mono_ctl_q[codec_regs_pkg::mono_out_mute_bit];
            if (mode3) begin
                // Right side comes from the extended mixer registers.
                mono_in_mute_r_q <= ext_mem_q[codec_regs_pkg::ext_input_mix]
                    [codec_regs_pkg::right_mute_bit];
                mono_out_mute_r_q <= ext_mem_q[codec_regs_pkg::ext_right_mix]
                    [codec_regs_pkg::right_mute_bit];
            end else begin
                mono_in_mute_r_q <=
                    mono_ctl_q[codec_regs_pkg::mono_in_mute_bit];
                mono_out_mute_r_q <=
                    mono_ctl_q[codec_regs_pkg::mono_out_mute_bit];
            end
        end
    end

    // Capture controls; the rate is set elsewhere for both paths.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            capture_stereo_q <= 1'b0;
            capture_format_q <= 3'h0;
            capture_base_q   <= 16'h0000;
            adpcm_freeze_q   <= 1'b0;
            ext_index_q      <= 4'h0;
        end else begin
            capture_stereo_q <= cap_fmt_q[codec_regs_pkg::cap_stereo_bit];
            capture_format_q <= cap_fmt_q[7:5];
            capture_base_q   <= {cap_upper_q, cap_lower_q};
            adpcm_freeze_q   <= ext_ctl_q[codec_regs_pkg::ext_freeze_bit];
            ext_index_q      <= ext_ctl_q[7:4];
        end
    end

endmodule : codec_indexed_regs

// file: tb/isa_host_model.sv
/* Host side bus master for the codec register ports.
   Assumes the bench calls its tasks from one process only. */
`timescale 1ns/1ps
module isa_host_model (
    input  wire logic       clk,   // Clock
    output logic      [1:0] addr,  // Port select
    output logic            wr,    // Write strobe
    output logic            rd,    // Read strobe
    output logic      [7:0] wdata  // Write data
);
    initial begin
        addr = 2'h0;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end
    task automatic wr_port(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        // A released bus must not keep showing the last byte.
        wdata = ~d;
    endtask : wr_port
    task automatic rd_port(input logic [1:0] a);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
    endtask : rd_port
    // Each extended access starts again from the index port.
    task automatic ext_sel(input logic [4:0] x, input logic frz);
        wr_port(2'h0, 8'h17);
        wr_port(2'h1, {x[3:0], 1'b1, x[4], 1'b0, frz});
    endtask : ext_sel
endmodule : isa_host_model

// file: tb/codec_indexed_regs_props.sv
/* Port checker for the indexed register block, bound to its top.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module codec_indexed_regs_props (
    input wire logic        clk,               // Clock
    input wire logic        resetn,            // Reset, low
    input wire logic        host_wr,           // Write strobe
    input wire logic        host_rd,           // Read strobe
    input wire logic [1:0]  codec_mode,        // Mode
    input wire logic [7:0]  host_rdata_q,      // Read data
    input wire logic [3:0]  ext_index_q,       // Extended index
    input wire logic        mono_bypass_q,     // Bypass
    input wire logic [3:0]  mono_path_atten_q, // Attenuation
    input wire logic        mono_in_mute_l_q,  // In mute left
    input wire logic        mono_in_mute_r_q,  // In mute right
    input wire logic        mono_out_mute_l_q, // Out mute left
    input wire logic        mono_out_mute_r_q, // Out mute right
    input wire logic        capture_stereo_q,  // Stereo
    input wire logic [2:0]  capture_format_q,  // Format
    input wire logic [15:0] capture_base_q,    // Base count
    input wire logic        adpcm_freeze_q     // Freeze
);
    logic [2:0] wr_h_q;
    logic [2:0] rd_h_q;
    // History lets a change be traced back to the strobe behind it.
    always_ff @(posedge clk) begin
        wr_h_q <= {wr_h_q[1:0], host_wr};
        rd_h_q <= {rd_h_q[1:0], host_rd};
    end
    wire wr_near = host_wr || (|wr_h_q);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_reset_clears: assert property (disable iff (1'b0) !resetn |=>
        capture_base_q == 16'h0000 && !adpcm_freeze_q)
        else $error("outputs not cleared by reset");
    a_base_needs_write: assert property ($changed(capture_base_q) |-> wr_near)
        else $error("capture base changed without a write");
    a_format_needs_write: assert property
        ($changed({capture_format_q, capture_stereo_q}) |-> wr_near)
        else $error("capture format changed without a write");
    a_freeze_needs_write: assert property ($changed(adpcm_freeze_q) |-> wr_near)
        else $error("freeze changed without a write");
    a_index_needs_write: assert property ($changed(ext_index_q) |-> wr_near)
        else $error("extended index changed without a write");
    a_rdata_stands: assert property ($changed(host_rdata_q) |-> |rd_h_q)
        else $error("read data changed without a read");
    a_mode_two_in: assert property
        ((codec_mode == codec_regs_pkg::mode_two) [*4]
        |-> mono_in_mute_l_q == mono_in_mute_r_q)
        else $error("mode two input mutes differ");
    a_mode_two_out: assert property
        ((codec_mode == codec_regs_pkg::mode_two) [*4]
        |-> mono_out_mute_l_q == mono_out_mute_r_q)
        else $error("mode two output mutes differ");
    a_bypass_atten: assert property (mono_bypass_q |-> mono_path_atten_q == 4'h3)
        else $error("bypass attenuation wrong");
    c_bypass: cover property (mono_bypass_q);
    c_stereo: cover property (capture_stereo_q);
    c_freeze: cover property (adpcm_freeze_q);
endmodule : codec_indexed_regs_props
bind codec_indexed_regs codec_indexed_regs_props props_inst (.clk, .resetn,
    .host_wr, .host_rd, .codec_mode, .host_rdata_q, .ext_index_q,
    .mono_bypass_q, .mono_path_atten_q, .mono_in_mute_l_q, .mono_in_mute_r_q,
    .mono_out_mute_l_q, .mono_out_mute_r_q, .capture_stereo_q,
    .capture_format_q, .capture_base_q, .adpcm_freeze_q);

// file: tb/tb_codec_indexed_regs.sv
/* Self-checking bench for the indexed register block.
   Assumes the host model drives the ports at falling edges. */
`timescale 1ns/1ps
module tb_codec_indexed_regs;
    logic        clk, resetn, cce, mb, mil, mir, mol, mor, cst, frz;
    logic [1:0]  mode, addr;
    logic        wr, rd;
    logic [7:0]  wdata, rdata, r;
    logic [3:0]  eidx, atn;
    logic [2:0]  fmt;
    logic [15:0] base;
    logic [7:0]  exp_q[$];
    int          n_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    event        rd_done;
    isa_host_model isa_host_model_inst (.clk(clk), .addr(addr), .wr(wr),
        .rd(rd), .wdata(wdata));
    codec_indexed_regs codec_indexed_regs_inst (.clk(clk), .resetn(resetn),
        .host_addr(addr), .host_wr(wr), .host_rd(rd), .host_wdata(wdata),
        .codec_mode(mode), .capture_change_en(cce), .host_rdata_q(rdata),
        .ext_index_q(eidx), .mono_bypass_q(mb), .mono_path_atten_q(atn),
        .mono_in_mute_l_q(mil), .mono_in_mute_r_q(mir),
        .mono_out_mute_l_q(mol), .mono_out_mute_r_q(mor),
        .capture_stereo_q(cst), .capture_format_q(fmt),
        .capture_base_q(base), .adpcm_freeze_q(frz));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic chk_out(input string nm, input logic [15:0] e, s);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk_out
    task automatic chk_rd(input logic [7:0] e, s);
        chk_out("rdata", e, s);
    endtask : chk_rd
    always @(rd_done) begin
        chk_rd(exp_q.pop_front(), rdata);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic w(input logic [1:0] a, input logic [7:0] d);
        isa_host_model_inst.wr_port(a, d);
    endtask : w
    task automatic rdx(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        isa_host_model_inst.rd_port(a);
        -> rd_done;
    endtask : rdx
    task automatic iwr(input logic [4:0] i, input logic [7:0] d);
        w(2'h0, {3'h0, i});
        w(2'h1, d);
    endtask : iwr
    task automatic ird(input logic [4:0] i, input logic [7:0] e);
        w(2'h0, {3'h0, i});
        rdx(2'h1, e);
    endtask : ird
    task automatic xwr(input logic [4:0] x, input logic [7:0] d);
        isa_host_model_inst.ext_sel(x, 1'b0);
        w(2'h1, d);
    endtask : xwr
    task automatic xrd(input logic [4:0] x, input logic [7:0] e);
        isa_host_model_inst.ext_sel(x, 1'b0);
        rdx(2'h1, e);
    endtask : xrd
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask : settle
    initial begin
        resetn = 1'b0;
        mode = codec_regs_pkg::mode_two;
        cce = 1'b0;
        r = 8'($urandom(32'hb6f3));
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        ird(codec_regs_pkg::idx_mono_ctl, 8'ha0);
        ird(codec_regs_pkg::idx_compat_id, 8'hb5);
        iwr(codec_regs_pkg::idx_compat_id, 8'h4a);
        ird(codec_regs_pkg::idx_compat_id, 8'hb5);
        ird(codec_regs_pkg::idx_rsvd_a, 8'h00);
        r = 8'($urandom);
        iwr(codec_regs_pkg::idx_cap_upper, r);
        iwr(codec_regs_pkg::idx_cap_lower, ~r);
        ird(codec_regs_pkg::idx_cap_upper, r);
        ird(codec_regs_pkg::idx_cap_lower, ~r);
        chk_out("base", {r, ~r}, base);
        r = (8'($urandom) & 8'hf0) | 8'h90;
        iwr(codec_regs_pkg::idx_cap_format, r);
        ird(codec_regs_pkg::idx_cap_format, 8'h00);
        cce = 1'b1;
        iwr(codec_regs_pkg::idx_cap_format, r);
        ird(codec_regs_pkg::idx_cap_format, r);
        chk_out("format", r[7:5], fmt);
        chk_out("stereo", r[4], cst);
        cce = 1'b0;
        w(2'h0, 8'h5c);
        w(2'h1, 8'h00);
        ird(codec_regs_pkg::idx_cap_format, 8'h00);
        for (int k = 0; k < 3; k++) begin
            r = (k == 0) ? (8'($urandom) & 8'h0f) : ((k == 1) ? 8'ha0 : 8'h65);
            iwr(codec_regs_pkg::idx_mono_ctl, r);
            settle();
            chk_out("bypass", r[6], mb);
            chk_out("atten", r[6] ? 4'h3 : r[3:0], atn);
            chk_out("in_mute", {2{r[5]}}, {mil, mir});
            chk_out("out_mute", {2{r[7]}}, {mol, mor});
        end
        xwr(codec_regs_pkg::ext_input_mix, 8'h00);
        mode = codec_regs_pkg::mode_three;
        iwr(codec_regs_pkg::idx_mono_ctl, 8'ha0);
        xrd(codec_regs_pkg::ext_input_mix, 8'h84);
        chk_out("out_mute", 2'b10, {mol, mor});
        xwr(codec_regs_pkg::ext_input_mix, 8'h00);
        xwr(codec_regs_pkg::ext_right_mix, 8'h80);
        settle();
        chk_out("in_mute", 2'b10, {mil, mir});
        chk_out("out_mute", 2'b11, {mol, mor});
        r = 8'($urandom);
        xwr(5'h00, r);
        xrd(5'h00, r);
        xrd(codec_regs_pkg::ext_id, codec_regs_pkg::ext_id_value);
        xwr(codec_regs_pkg::ext_rsvd_first, r | 8'h01);
        xrd(codec_regs_pkg::ext_rsvd_first, 8'h00);
        isa_host_model_inst.ext_sel(5'h09, 1'b1);
        settle();
        chk_out("ext_index", 4'h9, eidx);
        chk_out("freeze", 1'b1, frz);
        w(2'h0, 8'h17);
        rdx(2'h1, 8'h91);
        w(2'h1, 8'h00);
        settle();
        chk_out("freeze", 1'b0, frz);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        ird(codec_regs_pkg::idx_cap_upper, 8'h00);
        // Let the watcher take the last note before the verdict.
        settle();
        final_report();
    end
endmodule : tb_codec_indexed_regs
